/* File: core/fdp_params.sv */
// Top of the fieldbus drive profile parameter and command block
module fdp_params #(
	parameter int QSTOP_CYCLES = 16,
	parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
	parameter logic [15:0] UNIT_TYPE = 16'h0011, // Arbitrary value
	parameter logic [15:0] FW_YEAR = 16'h0000,
	parameter logic [15:0] FW_DDMM = 16'h0000
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Parameter access port
	input wire logic par_req_i,
	input wire logic par_wr_i,
	input wire logic [9:0] par_addr_i,
	input wire logic [2:0] par_subidx_i,
	input wire logic par_acyclic_i,
	input wire fdp_pkg::fdp_src_e par_src_i,
	input wire logic [15:0] par_wdata_i,
	output logic par_ack_o,
	output logic par_err_o,
	output logic [15:0] par_rdata_o,
	// Drive context
	input wire logic fieldbus_ctrl_i,
	input wire logic data_profile_i,
	input wire logic [15:0] firmware_version_i,
	input wire logic [3:0] line_rate_i,
	input wire logic fault_i,
	input wire logic [15:0] fault_code_i,
	input wire logic net_init_i,
	// Commands to motor control
	output logic drive_enable_o,
	output logic quick_stop_o,
	output logic fault_reset_o,
	output logic speed_ref_en_o,
	output logic [4:0] io_words_o
);
	// ************************************************************
	// Storage
	// ************************************************************
	logic [15:0] telegram_q; // Selected telegram
	logic [15:0] command_q; // Control word
	logic [15:0] fcount_q; // Fault message counter
	logic [3:0] rate_q; // Detected line rate
	logic [15:0] rdata_d;
	logic err_d;
	logic wr_ok;
	logic [15:0] code;
	logic clear;
	fdp_pkg::fdp_drv_e state;

	fdp_cmd_if cmd_bus ();

	// ************************************************************
	// Helpers
	// ************************************************************
	// Identity sub-index lookup
	function automatic logic [15:0] ident(input logic [2:0] s,
		input logic [15:0] fw);
		case (s)
			3'h0: ident = MAKER_CODE;
			3'h1: ident = UNIT_TYPE;
			3'h2: ident = fw;
			3'h3: ident = FW_YEAR;
			3'h4: ident = FW_DDMM;
			default: ident = fdp_pkg::IDENT_BAD_SUBIDX;
		endcase
	endfunction

	// ************************************************************
	// Submodules
	// ************************************************************
	fdp_cmd_decode u_dec (
		.word_i(command_q),
		.fieldbus_ctrl_i(fieldbus_ctrl_i),
		.data_profile_i(data_profile_i),
		.cmd(cmd_bus.src)
	);

	fdp_drive_seq #(.QSTOP_CYCLES(QSTOP_CYCLES)) u_seq (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.cmd(cmd_bus.dst),
		.fault_i(fault_i),
		.fault_code_i(fault_code_i),
		.state_o(state),
		.fault_clear_o(clear),
		.fault_code_o(code)
	);

	// ************************************************************
	// Write acceptance
	// ************************************************************
	always_comb begin
		wr_ok = 1'b0;
		if (par_req_i && par_wr_i) begin
			case (par_addr_i)
				fdp_pkg::ADDR_TELEGRAM_SELECT:
					wr_ok = par_wdata_i >= fdp_pkg::TELEGRAM_MIN &&
						par_wdata_i <= fdp_pkg::TELEGRAM_MAX; // R1
				fdp_pkg::ADDR_DRIVE_COMMAND_WORD:
					wr_ok = par_src_i == fdp_pkg::SRC_FIELDBUS; // R10
				default: wr_ok = 1'b0;
			endcase
		end
	end

	// Telegram selection, out of range writes refused
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			telegram_q <= fdp_pkg::TELEGRAM_RESET;
		end else if (wr_ok && par_addr_i == fdp_pkg::ADDR_TELEGRAM_SELECT) begin
			telegram_q <= par_wdata_i; // R1
		end
	end

	// Control word storage
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			command_q <= fdp_pkg::COMMAND_RESET;
		end else if (wr_ok && par_addr_i == fdp_pkg::ADDR_DRIVE_COMMAND_WORD) begin
			command_q <= par_wdata_i; // R10
		end
	end

	// Telegram size latched only at network initialisation
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			io_words_o <= 5'h02;
		end else if (net_init_i) begin
			io_words_o <= telegram_q[4:0]; // R1 R2
		end
	end

	// Fault counter; a new fault wins over a clear
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fcount_q <= 16'h0000;
		end else if (fault_i && state != fdp_pkg::DRV_FAULT) begin
			fcount_q <= fdp_pkg::FAULT_COUNT_MAX; // R3
		end else if (clear) begin
			fcount_q <= 16'h0000; // R4
		end
	end

	// Line rate code; out of range reads as not detected
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rate_q <= 4'h0;
		end else if (line_rate_i > fdp_pkg::RATE_MAX) begin
			rate_q <= fdp_pkg::RATE_NOT_DETECTED; // R6
		end else begin
			rate_q <= line_rate_i; // R6
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	always_comb begin
		rdata_d = 16'h0000;
		err_d = 1'b0;
		case (par_addr_i)
			fdp_pkg::ADDR_TELEGRAM_SELECT: rdata_d = telegram_q;
			fdp_pkg::ADDR_FAULT_MESSAGE_COUNTER: rdata_d = fcount_q;
			fdp_pkg::ADDR_ACTIVE_FAULT_CODE: rdata_d = code; // R5
			fdp_pkg::ADDR_DETECTED_LINE_RATE: rdata_d = {12'h000, rate_q};
			fdp_pkg::ADDR_DRIVE_IDENTITY_INFO: begin
				// Non acyclic paths always see sub-index 0
				if (!par_acyclic_i) begin
					rdata_d = ident(3'h0, firmware_version_i); // R7
				end else if (par_subidx_i > fdp_pkg::SUBIDX_MAX) begin
					err_d = 1'b1;
				end else begin
					rdata_d = ident(par_subidx_i, firmware_version_i); // R8
				end
			end
			fdp_pkg::ADDR_PROFILE_IDENTIFIER:
				rdata_d = {fdp_pkg::PROFILE_NUMBER,
					fdp_pkg::PROFILE_VERSION}; // R9
			fdp_pkg::ADDR_DRIVE_COMMAND_WORD: rdata_d = command_q;
			default: err_d = 1'b1;
		endcase
		if (par_wr_i && !wr_ok) begin
			err_d = 1'b1;
		end
	end

	// Answer registered one cycle after the request
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			par_ack_o <= 1'b0;
			par_err_o <= 1'b0;
			par_rdata_o <= 16'h0000;
		end else begin
			par_ack_o <= par_req_i;
			par_err_o <= par_req_i && err_d;
			par_rdata_o <= (par_req_i && !par_wr_i && !err_d) ? rdata_d : 16'h0000;
		end
	end

	// ************************************************************
	// Command outputs
	// ************************************************************
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drive_enable_o <= 1'b0;
			quick_stop_o <= 1'b0;
			fault_reset_o <= 1'b0;
			speed_ref_en_o <= 1'b0;
		end else begin
			drive_enable_o <= state == fdp_pkg::DRV_ENABLED;
			quick_stop_o <= state == fdp_pkg::DRV_QUICK_STOP; // R14
			fault_reset_o <= clear; // R17
			speed_ref_en_o <= cmd_bus.cmd_valid && cmd_bus.setpoint &&
				state == fdp_pkg::DRV_ENABLED; // R16
		end
	end
endmodule

/* File: core/fdp_pkg.sv */
// Constants and types for the fieldbus drive profile parameter block
// Notes on behaviour
// R1: Telegram selection 2 to 16, default 2
// R2: Telegram N gives N in, N out words
// R3: Fault counter increments on fault, max 1
// R4: Fault reset clears counter to zero
// R5: Fault code held while faulted, else zero
// R6: Detected line rate reported as code 0-11
// R7: Identity sub-indices 1-4 only via acyclic access
// R8: Sub-indices: maker, type, version, year, ddmm
// R9: Profile identifier: high 3, low 41
// R10: Command word writable only from fieldbus
// R11: Commands execute only when fieldbus controls
// R12: Bit 0 clear disables; set permits enable
// R13: Bit 1 clear coast stops and disables
// R14: Bit 2 clear quick stops then disables
// R15: Bit 3 set enables, clear disables
// R16: Bit 6 selects fieldbus speed or zero
// R17: Bit 7 resets fault while faulted
// R18: Bits 4, 8, 10 and reserved ignored
// R19: Command word applies only in profile 0
// R20: Master writes zero to unused bits
package fdp_pkg;
	// ************************************************************
	// Parameter numbers used as addresses on the parameter port
	// ************************************************************
	localparam logic [9:0] ADDR_TELEGRAM_SELECT = 10'h39a; // 922
	localparam logic [9:0] ADDR_FAULT_MESSAGE_COUNTER = 10'h3b0; // 944
	localparam logic [9:0] ADDR_ACTIVE_FAULT_CODE = 10'h3b3; // 947
	localparam logic [9:0] ADDR_DETECTED_LINE_RATE = 10'h3c3; // 963
	localparam logic [9:0] ADDR_DRIVE_IDENTITY_INFO = 10'h3c4; // 964
	localparam logic [9:0] ADDR_PROFILE_IDENTIFIER = 10'h3c5; // 965
	localparam logic [9:0] ADDR_DRIVE_COMMAND_WORD = 10'h3c7; // 967

	// ************************************************************
	// Reset values and ranges
	// ************************************************************
	localparam logic [15:0] TELEGRAM_RESET = 16'h0002;
	localparam logic [15:0] TELEGRAM_MIN = 16'h0002;
	localparam logic [15:0] TELEGRAM_MAX = 16'h0010;
	localparam logic [15:0] COMMAND_RESET = 16'h0000;
	localparam logic [15:0] FAULT_COUNT_MAX = 16'h0001;
	localparam logic [3:0] RATE_NOT_DETECTED = 4'h5;
	localparam logic [3:0] RATE_MAX = 4'hb;
	localparam logic [7:0] PROFILE_NUMBER = 8'h03;
	localparam logic [7:0] PROFILE_VERSION = 8'h29;
	localparam logic [2:0] SUBIDX_MAX = 3'h4;
	localparam logic [15:0] IDENT_BAD_SUBIDX = 16'h0000;

	// ************************************************************
	// Command word bit positions
	// ************************************************************
	localparam int CMD_ON = 0;
	localparam int CMD_NO_COAST = 1;
	localparam int CMD_NO_QUICK = 2;
	localparam int CMD_ENABLE_OP = 3;
	localparam int CMD_SETPOINT = 6;
	localparam int CMD_FAULT_ACK = 7;

	// ************************************************************
	// Access sources and selections
	// ************************************************************
	typedef enum logic [1:0] {
		SRC_FIELDBUS,
		SRC_PANEL,
		SRC_SERIAL,
		SRC_OTHER
	} fdp_src_e;

	localparam logic data_profile_standard = 1'b0;

	// Drive command sequencing state
	typedef enum logic [1:0] {
		DRV_DISABLED,
		DRV_ENABLED,
		DRV_QUICK_STOP,
		DRV_FAULT
	} fdp_drv_e;
endpackage

/* File: core/fdp_cmd_if.sv */
// Interface carrying decoded drive commands between modules
interface fdp_cmd_if;
	logic cmd_valid; // Commands may act this cycle
	logic on_ok; // Bit 0 permit
	logic no_coast; // Bit 1 permit
	logic no_quick; // Bit 2 permit
	logic enable_op; // Bit 3 enable
	logic setpoint; // Bit 6 setpoint source
	logic fault_ack; // Bit 7 acknowledge
	modport src (output cmd_valid, on_ok, no_coast, no_quick, enable_op,
		setpoint, fault_ack);
	modport dst (input cmd_valid, on_ok, no_coast, no_quick, enable_op,
		setpoint, fault_ack);
endinterface

/* File: core/fdp_cmd_decode.sv */
// Decoder from the command word into separate command levels
module fdp_cmd_decode (
	// Command word and qualifiers
	input wire logic [15:0] word_i,
	input wire logic fieldbus_ctrl_i,
	input wire logic data_profile_i,
	// Decoded commands
	fdp_cmd_if.src cmd
);
	// Bits 4, 5, 8 to 15 are never looked at
	always_comb begin // R18
		cmd.cmd_valid = fieldbus_ctrl_i && // R11
			(data_profile_i == fdp_pkg::data_profile_standard); // R19
		cmd.on_ok = word_i[fdp_pkg::CMD_ON];
		cmd.no_coast = word_i[fdp_pkg::CMD_NO_COAST];
		cmd.no_quick = word_i[fdp_pkg::CMD_NO_QUICK];
		cmd.enable_op = word_i[fdp_pkg::CMD_ENABLE_OP];
		cmd.setpoint = word_i[fdp_pkg::CMD_SETPOINT];
		cmd.fault_ack = word_i[fdp_pkg::CMD_FAULT_ACK];
	end
endmodule

/* File: core/fdp_drive_seq.sv */
// Drive enable sequencer acting on decoded commands and faults
module fdp_drive_seq #(
	parameter int QSTOP_CYCLES = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Commands and fault events
	fdp_cmd_if.dst cmd,
	input wire logic fault_i,
	input wire logic [15:0] fault_code_i,
	// State out
	output fdp_pkg::fdp_drv_e state_o,
	output logic fault_clear_o,
	output logic [15:0] fault_code_o
);
	fdp_pkg::fdp_drv_e state_q;
	logic [15:0] qcnt_q; // Quick stop ramp timer
	logic [15:0] code_q; // Latched fault code
	logic permit;
	logic ack;

	assign permit = cmd.on_ok && cmd.no_coast && cmd.no_quick;
	assign ack = cmd.cmd_valid && cmd.fault_ack;
	assign state_o = state_q;
	assign fault_code_o = code_q;
	assign fault_clear_o = (state_q == fdp_pkg::DRV_FAULT) && ack && !fault_i;

	// Enable state machine; faults win over every command
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= fdp_pkg::DRV_DISABLED;
		end else begin
			case (state_q)
				fdp_pkg::DRV_DISABLED: begin
					if (fault_i) begin
						state_q <= fdp_pkg::DRV_FAULT;
					end else if (cmd.cmd_valid && permit && cmd.enable_op) begin
						state_q <= fdp_pkg::DRV_ENABLED; // R15
					end
				end
				fdp_pkg::DRV_ENABLED: begin
					if (fault_i) begin
						state_q <= fdp_pkg::DRV_FAULT;
					end else if (cmd.cmd_valid && !cmd.no_quick) begin
						state_q <= fdp_pkg::DRV_QUICK_STOP; // R14
					end else if (cmd.cmd_valid &&
						(!cmd.on_ok || !cmd.no_coast || !cmd.enable_op)) begin
						state_q <= fdp_pkg::DRV_DISABLED; // R12 R13 R15
					end
				end
				fdp_pkg::DRV_QUICK_STOP: begin
					if (fault_i) begin
						state_q <= fdp_pkg::DRV_FAULT;
					end else if (qcnt_q == 16'h0000) begin
						state_q <= fdp_pkg::DRV_DISABLED; // R14
					end
				end
				fdp_pkg::DRV_FAULT: begin
					if (fault_clear_o) begin
						state_q <= fdp_pkg::DRV_DISABLED; // R17
					end
				end
				default: state_q <= fdp_pkg::DRV_DISABLED;
			endcase
		end
	end

	// Quick stop timer, loaded on entry, counts to zero
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			qcnt_q <= 16'h0000;
		end else if (state_q != fdp_pkg::DRV_QUICK_STOP) begin
			qcnt_q <= 16'(QSTOP_CYCLES - 1);
		end else if (qcnt_q != 16'h0000) begin
			qcnt_q <= qcnt_q - 16'h0001;
		end
	end

	// Fault code held while faulted, zero otherwise
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			code_q <= 16'h0000;
		end else if (fault_i && state_q != fdp_pkg::DRV_FAULT) begin
			code_q <= fault_code_i; // R5
		end else if (fault_clear_o) begin
			code_q <= 16'h0000; // R5
		end
	end
endmodule

/* File: tb/fdp_params_checker.sv */
// Concurrent checks on the parameter block ports
module fdp_params_checker (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Access port
	input wire logic par_req_i,
	input wire logic par_wr_i,
	input wire logic [9:0] par_addr_i,
	input wire fdp_pkg::fdp_src_e par_src_i,
	input wire logic [15:0] par_wdata_i,
	input wire logic par_ack_o,
	input wire logic par_err_o,
	input wire logic [15:0] par_rdata_o,
	// Drive context and commands
	input wire logic fieldbus_ctrl_i,
	input wire logic data_profile_i,
	input wire logic fault_i,
	input wire logic net_init_i,
	input wire logic drive_enable_o,
	input wire logic quick_stop_o,
	input wire logic fault_reset_o,
	input wire logic [4:0] io_words_o
);
	// ****
	// Helpers
	// ****
	logic rd; // Read request
	logic wr; // Write request
	assign rd = par_req_i && !par_wr_i;
	assign wr = par_req_i && par_wr_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// ****
	// Assertions
	// ****
	a_ack_timing: assert property (
		par_ack_o == $past(par_req_i)) else $error("ack timing");
	a_profile_word: assert property (
		rd && par_addr_i == 10'h3c5 |=> par_rdata_o == 16'h0329
		&& !par_err_o) else $error("profile id");
	a_cmd_src_only: assert property (
		wr && par_addr_i == 10'h3c7 && par_src_i !=
		fdp_pkg::SRC_FIELDBUS |=> par_err_o) else $error("cmd src");
	a_tel_range: assert property (
		wr && par_addr_i == 10'h39a && (par_wdata_i < 16'h0002 ||
		par_wdata_i > 16'h0010) |=> par_err_o) else $error("tel range");
	a_count_max: assert property (
		rd && par_addr_i == 10'h3b0 |=> par_rdata_o <= 16'h0001)
		else $error("count max");
	a_enable_cause: assert property (
		$rose(drive_enable_o) |-> $past(fieldbus_ctrl_i, 2) &&
		!$past(data_profile_i, 2)) else $error("enable cause");
	a_qstop_off: assert property (
		$fell(quick_stop_o) |-> !drive_enable_o) else $error("qstop");
	a_fault_clear: assert property (
		fault_reset_o |-> !$past(fault_i)) else $error("fault clr");
	a_words_latch: assert property (
		$changed(io_words_o) |-> $past(net_init_i)) else $error("words");
endmodule
bind fdp_params fdp_params_checker chk (.clk_i(clk_i), .rstn_i(rstn_i),
	.par_req_i(par_req_i), .par_wr_i(par_wr_i), .par_addr_i(par_addr_i),
	.par_src_i(par_src_i), .par_wdata_i(par_wdata_i),
	.par_ack_o(par_ack_o), .par_err_o(par_err_o),
	.par_rdata_o(par_rdata_o), .fieldbus_ctrl_i(fieldbus_ctrl_i),
	.data_profile_i(data_profile_i), .fault_i(fault_i),
	.net_init_i(net_init_i), .drive_enable_o(drive_enable_o),
	.quick_stop_o(quick_stop_o), .fault_reset_o(fault_reset_o),
	.io_words_o(io_words_o));

/* File: tb/fdp_master_model.sv */
// Network master model making parameter accesses
module fdp_master_model (
	// Clock
	input wire logic clk_i,
	// Request side
	output logic req_o,
	output logic wr_o,
	output logic [9:0] addr_o,
	output logic [2:0] sub_o,
	output logic acyc_o,
	output fdp_pkg::fdp_src_e src_o,
	output logic [15:0] wdata_o,
	// Answer side
	input wire logic ack_i,
	input wire logic err_i,
	input wire logic [15:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		{req_o, wr_o, addr_o, sub_o, acyc_o, wdata_o} = '0;
		src_o = fdp_pkg::SRC_FIELDBUS;
	end
	// One access; then write, address and data lines flip so stale values never match
	task automatic xfer(input logic w, input logic [9:0] a,
		input logic [2:0] s, input logic ac, input fdp_pkg::fdp_src_e sr,
		input logic [15:0] d, output logic [17:0] r);
		@(posedge clk_i);
		#1;
		{req_o, wr_o, addr_o, sub_o, acyc_o, src_o, wdata_o} =
			{1'b1, w, a, s, ac, sr, d};
		@(posedge clk_i);
		#1;
		req_o = 1'b0;
		r = {ack_i, err_i, rdata_i};
		{wr_o, addr_o, wdata_o} = ~{w, a, d};
	endtask
endmodule

/* File: tb/fdp_params_tb.sv */
// Self-checking bench for the parameter and command block
module fdp_params_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] MK = 16'h00a5; // Arbitrary value
	localparam logic [15:0] UT = 16'h0011; // Arbitrary value
	localparam fdp_pkg::fdp_src_e FB = fdp_pkg::SRC_FIELDBUS;
	logic clk_i, rstn_i, req, wr, acyc, ack, err, fb, dp, flt, ninit;
	logic drv_en, qstop, frst, spd;
	logic [9:0] addr;
	logic [2:0] sub;
	logic [3:0] rate;
	logic [4:0] iow;
	logic [15:0] wdat, rdat, fcode;
	fdp_pkg::fdp_src_e src;
	int err_total, cmp_count, cyc;
	// ****
	// Block and master
	// ****
	fdp_params #(.QSTOP_CYCLES(4), .MAKER_CODE(MK), .UNIT_TYPE(UT),
		.FW_YEAR(16'h1234), .FW_DDMM(16'h0506)) uut (.clk_i(clk_i),
		.rstn_i(rstn_i), .par_req_i(req), .par_wr_i(wr),
		.par_addr_i(addr), .par_subidx_i(sub), .par_acyclic_i(acyc),
		.par_src_i(src), .par_wdata_i(wdat), .par_ack_o(ack),
		.par_err_o(err), .par_rdata_o(rdat), .fieldbus_ctrl_i(fb),
		.data_profile_i(dp), .firmware_version_i(16'h0123),
		.line_rate_i(rate), .fault_i(flt), .fault_code_i(fcode),
		.net_init_i(ninit), .drive_enable_o(drv_en),
		.quick_stop_o(qstop), .fault_reset_o(frst),
		.speed_ref_en_o(spd), .io_words_o(iow));
	fdp_master_model mst (.clk_i(clk_i), .req_o(req), .wr_o(wr),
		.addr_o(addr), .sub_o(sub), .acyc_o(acyc), .src_o(src),
		.wdata_o(wdat), .ack_i(ack), .err_i(err), .rdata_i(rdat));
	// ****
	// Shared tasks
	// ****
	task automatic chk(input logic [17:0] g, input logic [17:0] x);
		cmp_count++;
		if (g !== x) begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, g, x);
		end
	endtask
	// Access with ack, error flag and data checked at once
	task automatic acc(input logic w, input logic [9:0] a,
		input logic [2:0] s, input logic ac, input fdp_pkg::fdp_src_e sr,
		input logic [15:0] d, input logic xe, input logic [15:0] x);
		logic [17:0] r;
		mst.xfer(w, a, s, ac, sr, d, r);
		chk(r, {1'b1, xe, (w || xe) ? 16'h0000 : x});
	endtask
	// Store a command word and check the enable a few cycles on
	task automatic cmd(input logic [15:0] d, input logic en);
		acc(1'b1, 10'h3c7, 3'h0, 1'b0, FB, d, 1'b0, 16'h0000);
		repeat (3) @(posedge clk_i);
		#1;
		chk(drv_en, en);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_ident();
		logic [15:0] id [5] = '{MK, UT, 16'h0123, 16'h1234, 16'h0506};
		chk(iow, 5'h02);
		acc(1'b0, 10'h39a, 3'h0, 1'b0, FB, 16'h0, 1'b0, 16'h0002);
		acc(1'b0, 10'h3c7, 3'h0, 1'b0, FB, 16'h0, 1'b0, 16'h0000);
		acc(1'b0, 10'h3c5, 3'h0, 1'b0, FB, 16'h0, 1'b0, 16'h0329);
		acc(1'b1, 10'h3c5, 3'h0, 1'b0, FB, 16'h1, 1'b1, 16'h0000);
		for (int i = 0; i < 5; i++)
			acc(1'b0, 10'h3c4, i, 1'b1, FB, 16'h0, 1'b0, id[i]);
		acc(1'b0, 10'h3c4, 3'h3, 1'b0, FB, 16'h0, 1'b0, MK);
		acc(1'b0, 10'h3c4, 3'h5, 1'b1, FB, 16'h0, 1'b1, 16'h0);
	endtask
	task automatic t_tel();
		acc(1'b1, 10'h39a, 3'h0, 1'b0, FB, 16'h1, 1'b1, 16'h0);
		acc(1'b1, 10'h39a, 3'h0, 1'b0, FB, 16'h11, 1'b1, 16'h0);
		acc(1'b1, 10'h39a, 3'h0, 1'b0, FB, 16'h10, 1'b0, 16'h0);
		acc(1'b0, 10'h39a, 3'h0, 1'b0, FB, 16'h0, 1'b0, 16'h10);
		chk(iow, 5'h02);
		ninit = 1'b1;
		@(posedge clk_i);
		#1;
		ninit = 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		chk(iow, 5'h10);
	endtask
	task automatic t_rate();
		for (int i = 0; i < 16; i++) begin
			rate = i;
			acc(1'b0, 10'h3c3, 3'h0, 1'b0, FB, 16'h0, 1'b0,
				(i > 11) ? 16'h5 : 16'(i));
		end
	endtask
	task automatic t_drive();
		for (int i = 1; i < 4; i++)
			acc(1'b1, 10'h3c7, 0, 0, fdp_pkg::fdp_src_e'(i), 16'hf, 1, 0);
		cmd(16'h004f, 1'b1);
		chk(spd, 1'b1);
		cmd(16'h000f, 1'b1);
		chk(spd, 1'b0);
		cmd(16'h000d, 1'b0);
		cmd(16'h000f, 1'b1);
		cmd(16'h000e, 1'b0);
		cmd(16'h051f, 1'b1);
		cmd(16'h0007, 1'b0);
		cmd(16'h000f, 1'b1);
		acc(1'b1, 10'h3c7, 3'h0, 1'b0, FB, 16'h000b, 1'b0, 16'h0);
		repeat (2) @(posedge clk_i);
		#1;
		chk(qstop, 1'b1);
		repeat (8) @(posedge clk_i);
		#1;
		chk({qstop, drv_en}, 2'b00);
		fb = 1'b0;
		cmd(16'h000f, 1'b0);
		fb = 1'b1;
		dp = 1'b1;
		cmd(16'h000f, 1'b0);
		dp = 1'b0;
		cmd(16'h000f, 1'b1);
	endtask
	task automatic t_fault();
		logic seen;
		fcode = 16'h0042;
		flt = 1'b1;
		repeat (2) @(posedge clk_i);
		acc(1'b0, 10'h3b0, 3'h0, 1'b0, FB, 16'h0, 1'b0, 16'h1);
		acc(1'b0, 10'h3b3, 3'h0, 1'b0, FB, 16'h0, 1'b0, 16'h42);
		flt = 1'b0;
		cmd(16'h000f, 1'b0);
		acc(1'b0, 10'h3b0, 3'h0, 1'b0, FB, 16'h0, 1'b0, 16'h1);
		acc(1'b1, 10'h3c7, 3'h0, 1'b0, FB, 16'h008f, 1'b0, 16'h0);
		seen = 1'b0;
		repeat (4) begin
			@(posedge clk_i);
			#1;
			seen = seen | frst;
		end
		chk(seen, 1'b1);
		acc(1'b0, 10'h3b0, 3'h0, 1'b0, FB, 16'h0, 1'b0, 16'h0);
		acc(1'b0, 10'h3b3, 3'h0, 1'b0, FB, 16'h0, 1'b0, 16'h0);
	endtask
	// ****
	// Run control
	// ****
	task automatic report_and_stop();
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Cycle ceiling cuts a hang short
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			report_and_stop();
		end
	end
	initial begin
		{rstn_i, fb, dp, flt, ninit, rate, fcode} = '0;
		fb = 1'b1;
		repeat (8) @(posedge clk_i);
		#1;
		rstn_i = 1'b1;
		t_ident();
		t_tel();
		t_rate();
		t_drive();
		t_fault();
		report_and_stop();
	end
endmodule
